// file: logic/sram_wr_pkg.sv
// Constants and field layout of the write port and shared address logic.
package sram_wr_pkg;
    // Word and lane geometry of the 36-bit configuration
    localparam int DATA_W = 36;
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int LANE0_LSB = 0;
    localparam int LANE1_LSB = 9;
    localparam int LANE2_LSB = 18;
    localparam int LANE3_LSB = 27;
    // Address and array depth
    localparam int ADDR_W = 17;
    localparam int SUB_ARRAYS = 4;
    localparam int ARRAY_WORDS = 131072;
    // Burst beat slots inside one address
    localparam int BEAT0 = 0;
    localparam int BEAT1 = 1;
    localparam int BEAT2 = 2;
    localparam int BEAT3 = 3;
    // Reset values of the link side registers, and the all-deselected byte select code
    localparam logic DRIVE_OFF = 1'b1;
    localparam logic [DATA_W-1:0] DATA_RESET = 36'h0_0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 17'h0_0000;
    localparam logic [3:0] SEL_NONE = 4'hf;
    // Burst phase of each port, one positive clock period per phase
    typedef enum logic [1:0] {PH_IDLE, PH_FIRST, PH_SECOND} phase_t;
endpackage

// file: logic/sram_wr_port.sv
// Write port, shared address latch and array of the burst SRAM.
module sram_wr_port (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic k_clk_i,
    input wire logic k_n_clk_i,
    input wire logic write_port_select_n_i,
    input wire logic read_port_select_n_i,
    input wire logic byte_lane0_write_sel_n_i,
    input wire logic byte_lane1_write_sel_n_i,
    input wire logic byte_lane2_write_sel_n_i,
    input wire logic byte_lane3_write_sel_n_i,
    input wire logic [sram_wr_pkg::ADDR_W-1:0] addr_i,
    input wire logic [sram_wr_pkg::DATA_W-1:0] wr_data_i,
    output logic [sram_wr_pkg::DATA_W-1:0] q_rise_o,
    output logic [sram_wr_pkg::DATA_W-1:0] q_fall_o,
    output logic q_drive_n_o,
    output logic output_valid_flag_o,
    output logic write_done_o,
    output logic read_start_o
);
    // Expand active-low byte selects to a per-bit write mask
    function automatic logic [sram_wr_pkg::DATA_W-1:0] lane_mask(input logic [3:0] sel_n);
        logic [sram_wr_pkg::DATA_W-1:0] m;
        m = '0;
        m[sram_wr_pkg::LANE0_LSB +: sram_wr_pkg::LANE_W] = {sram_wr_pkg::LANE_W{!sel_n[0]}};
        m[sram_wr_pkg::LANE1_LSB +: sram_wr_pkg::LANE_W] = {sram_wr_pkg::LANE_W{!sel_n[1]}};
        m[sram_wr_pkg::LANE2_LSB +: sram_wr_pkg::LANE_W] = {sram_wr_pkg::LANE_W{!sel_n[2]}};
        m[sram_wr_pkg::LANE3_LSB +: sram_wr_pkg::LANE_W] = {sram_wr_pkg::LANE_W{!sel_n[3]}};
        return m;
    endfunction

    // Keep old bits where the mask is clear
    function automatic logic [sram_wr_pkg::DATA_W-1:0] merge(
        input logic [sram_wr_pkg::DATA_W-1:0] old_w,
        input logic [sram_wr_pkg::DATA_W-1:0] new_w,
        input logic [sram_wr_pkg::DATA_W-1:0] mask);
        return (old_w & ~mask) | (new_w & mask);
    endfunction

    // Four sub-arrays, one per burst beat
    logic [sram_wr_pkg::DATA_W-1:0] mem [sram_wr_pkg::SUB_ARRAYS][sram_wr_pkg::ARRAY_WORDS];

    // Reset synchronisers, one per clock
    logic sys_rst_a_reg;
    logic sys_rst_n;
    logic k_rst_a_reg;
    logic k_rst_n;
    logic kn_rst_a_reg;
    logic kn_rst_n;
    // Port phases and latched addresses
    sram_wr_pkg::phase_t wr_state;
    sram_wr_pkg::phase_t rd_state;
    logic [sram_wr_pkg::ADDR_W-1:0] wr_addr_reg;
    logic [sram_wr_pkg::ADDR_W-1:0] rd_addr_reg;
    // Beat 1 caught on the positive clock
    logic [sram_wr_pkg::DATA_W-1:0] beat1_reg;
    logic [sram_wr_pkg::DATA_W-1:0] mask1_reg;
    // Beats caught on the negative clock
    logic [sram_wr_pkg::DATA_W-1:0] beat0_reg;
    logic [sram_wr_pkg::DATA_W-1:0] mask0_reg;
    logic [sram_wr_pkg::DATA_W-1:0] beat2_reg;
    logic [sram_wr_pkg::DATA_W-1:0] mask2_reg;
    // Read outputs
    logic [sram_wr_pkg::DATA_W-1:0] q_rise_reg;
    logic [sram_wr_pkg::DATA_W-1:0] q_fall_reg;
    logic q_drive_n_reg;
    logic valid_reg; // Own flop, so the valid pin carries no gate
    // Event toggles crossing into the system clock
    logic wr_tog_reg;
    logic rd_tog_reg;
    logic [2:0] wr_sync_reg;
    logic [2:0] rd_sync_reg;
    logic wr_seen_reg;
    logic rd_seen_reg;
    logic write_done_reg;
    logic read_start_reg;
    // Request decode
    logic rd_accept;
    logic wr_accept;
    logic [3:0] sel_n;
    logic [sram_wr_pkg::DATA_W-1:0] cur_mask;

    // System reset release
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            {sys_rst_n, sys_rst_a_reg} <= 2'b00;
        else
            {sys_rst_n, sys_rst_a_reg} <= {sys_rst_a_reg, 1'b1};
    end

    // Link reset release on the positive clock
    always_ff @(posedge k_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            {k_rst_n, k_rst_a_reg} <= 2'b00;
        else
            {k_rst_n, k_rst_a_reg} <= {k_rst_a_reg, 1'b1};
    end

    // Link reset release on the negative clock
    always_ff @(posedge k_n_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            {kn_rst_n, kn_rst_a_reg} <= 2'b00;
        else
            {kn_rst_n, kn_rst_a_reg} <= {kn_rst_a_reg, 1'b1};
    end

    // Selects and mask of the beat on the pins now
    assign sel_n = {byte_lane3_write_sel_n_i, byte_lane2_write_sel_n_i,
                    byte_lane1_write_sel_n_i, byte_lane0_write_sel_n_i};
    assign cur_mask = lane_mask(sel_n);

    // Read takes the shared address when both ask on one edge
    assign rd_accept = !read_port_select_n_i && rd_state != sram_wr_pkg::PH_FIRST;
    assign wr_accept = !write_port_select_n_i && wr_state != sram_wr_pkg::PH_FIRST
                       && !rd_accept;

    // Write port phase, only the positive clock starts a burst
    always_ff @(posedge k_clk_i or negedge k_rst_n)
    begin
        if (!k_rst_n)
            wr_state <= sram_wr_pkg::PH_IDLE;
        else if (wr_accept)
            wr_state <= sram_wr_pkg::PH_FIRST;
        else if (wr_state == sram_wr_pkg::PH_FIRST)
            wr_state <= sram_wr_pkg::PH_SECOND;
        else
            // Deselected: data pins play no part
            wr_state <= sram_wr_pkg::PH_IDLE;
    end

    // Read port phase
    always_ff @(posedge k_clk_i or negedge k_rst_n)
    begin
        if (!k_rst_n)
            rd_state <= sram_wr_pkg::PH_IDLE;
        else if (rd_accept)
            rd_state <= sram_wr_pkg::PH_FIRST;
        else if (rd_state == sram_wr_pkg::PH_FIRST)
            rd_state <= sram_wr_pkg::PH_SECOND;
        else
            rd_state <= sram_wr_pkg::PH_IDLE;
    end

    // Address latch, held while the port is deselected
    always_ff @(posedge k_clk_i or negedge k_rst_n)
    begin
        if (!k_rst_n)
        begin
            wr_addr_reg <= sram_wr_pkg::ADDR_RESET;
            rd_addr_reg <= sram_wr_pkg::ADDR_RESET;
        end
        else if (rd_accept)
            rd_addr_reg <= addr_i;
        else if (wr_accept)
            wr_addr_reg <= addr_i;
    end

    // Beat 1 caught at the end of the first write phase
    always_ff @(posedge k_clk_i or negedge k_rst_n)
    begin
        if (!k_rst_n)
        begin
            beat1_reg <= sram_wr_pkg::DATA_RESET;
            mask1_reg <= sram_wr_pkg::DATA_RESET;
        end
        else if (wr_state == sram_wr_pkg::PH_FIRST)
        begin
            beat1_reg <= wr_data_i;
            mask1_reg <= cur_mask;
        end
    end

    // Beats 0 and 2 on the negative clock; phase is stable half a period here
    always_ff @(posedge k_n_clk_i or negedge kn_rst_n)
    begin
        if (!kn_rst_n)
        begin
            beat0_reg <= sram_wr_pkg::DATA_RESET;
            mask0_reg <= sram_wr_pkg::DATA_RESET;
            beat2_reg <= sram_wr_pkg::DATA_RESET;
            mask2_reg <= sram_wr_pkg::DATA_RESET;
        end
        else if (wr_state == sram_wr_pkg::PH_FIRST)
        begin
            beat0_reg <= wr_data_i;
            mask0_reg <= cur_mask;
        end
        else if (wr_state == sram_wr_pkg::PH_SECOND)
        begin
            beat2_reg <= wr_data_i;
            mask2_reg <= cur_mask;
        end
    end

    // Commit all four beats at the end of the second phase
    always_ff @(posedge k_clk_i)
    begin
        if (k_rst_n && wr_state == sram_wr_pkg::PH_SECOND)
        begin
            mem[sram_wr_pkg::BEAT0][wr_addr_reg] <= merge(mem[sram_wr_pkg::BEAT0][wr_addr_reg],
                beat0_reg, mask0_reg);
            mem[sram_wr_pkg::BEAT1][wr_addr_reg] <= merge(mem[sram_wr_pkg::BEAT1][wr_addr_reg],
                beat1_reg, mask1_reg);
            mem[sram_wr_pkg::BEAT2][wr_addr_reg] <= merge(mem[sram_wr_pkg::BEAT2][wr_addr_reg],
                beat2_reg, mask2_reg);
            mem[sram_wr_pkg::BEAT3][wr_addr_reg] <= merge(mem[sram_wr_pkg::BEAT3][wr_addr_reg],
                wr_data_i, cur_mask);
        end
    end

    // Rising-edge read words 1 and 3
    always_ff @(posedge k_clk_i or negedge k_rst_n)
    begin
        if (!k_rst_n)
            q_rise_reg <= sram_wr_pkg::DATA_RESET;
        else if (rd_state == sram_wr_pkg::PH_FIRST)
            q_rise_reg <= mem[sram_wr_pkg::BEAT1][rd_addr_reg];
        else if (rd_state == sram_wr_pkg::PH_SECOND)
            q_rise_reg <= mem[sram_wr_pkg::BEAT3][rd_addr_reg];
    end

    // Falling-edge read words 0 and 2
    always_ff @(posedge k_n_clk_i or negedge kn_rst_n)
    begin
        if (!kn_rst_n)
            q_fall_reg <= sram_wr_pkg::DATA_RESET;
        else if (rd_state == sram_wr_pkg::PH_FIRST)
            q_fall_reg <= mem[sram_wr_pkg::BEAT0][rd_addr_reg];
        else if (rd_state == sram_wr_pkg::PH_SECOND)
            q_fall_reg <= mem[sram_wr_pkg::BEAT2][rd_addr_reg];
    end

    // Drivers on from the accept edge until one period after the burst
    always_ff @(posedge k_clk_i or negedge k_rst_n)
    begin
        if (!k_rst_n)
        begin
            q_drive_n_reg <= sram_wr_pkg::DRIVE_OFF;
            valid_reg <= !sram_wr_pkg::DRIVE_OFF;
        end
        else
        begin
            q_drive_n_reg <= rd_state == sram_wr_pkg::PH_IDLE && !rd_accept;
            valid_reg <= rd_state != sram_wr_pkg::PH_IDLE || rd_accept;
        end
    end

    // Event toggles toward the system clock
    always_ff @(posedge k_clk_i or negedge k_rst_n)
    begin
        if (!k_rst_n)
        begin
            wr_tog_reg <= 1'b0;
            rd_tog_reg <= 1'b0;
        end
        else
        begin
            wr_tog_reg <= wr_tog_reg ^ (wr_state == sram_wr_pkg::PH_SECOND);
            rd_tog_reg <= rd_tog_reg ^ rd_accept;
        end
    end

    // Three-stage sync; a change counts once stages two and three agree
    always_ff @(posedge clock_i or negedge sys_rst_n)
    begin
        if (!sys_rst_n)
        begin
            wr_sync_reg <= 3'h0;
            rd_sync_reg <= 3'h0;
            wr_seen_reg <= 1'b0;
            rd_seen_reg <= 1'b0;
            write_done_reg <= 1'b0;
            read_start_reg <= 1'b0;
        end
        else
        begin
            wr_sync_reg <= {wr_sync_reg[1:0], wr_tog_reg};
            rd_sync_reg <= {rd_sync_reg[1:0], rd_tog_reg};
            write_done_reg <= 1'b0;
            read_start_reg <= 1'b0;
            if (wr_sync_reg[1] == wr_sync_reg[2] && wr_sync_reg[2] != wr_seen_reg)
            begin
                wr_seen_reg <= wr_sync_reg[2];
                write_done_reg <= 1'b1;
            end
            if (rd_sync_reg[1] == rd_sync_reg[2] && rd_sync_reg[2] != rd_seen_reg)
            begin
                rd_seen_reg <= rd_sync_reg[2];
                read_start_reg <= 1'b1;
            end
        end
    end

    // Outputs straight from flip-flops
    assign q_rise_o = q_rise_reg;
    assign q_fall_o = q_fall_reg;
    assign q_drive_n_o = q_drive_n_reg;
    assign output_valid_flag_o = valid_reg;
    assign write_done_o = write_done_reg;
    assign read_start_o = read_start_reg;

    // Burst shapes on the positive clock
    sequence s_wr_burst;
        wr_state == sram_wr_pkg::PH_FIRST ##1 wr_state == sram_wr_pkg::PH_SECOND;
    endsequence
    sequence s_rd_burst;
        rd_state == sram_wr_pkg::PH_FIRST ##1 rd_state == sram_wr_pkg::PH_SECOND;
    endsequence
    property p_wr_start;
        @(posedge k_clk_i) disable iff (!k_rst_n)
        (!write_port_select_n_i && read_port_select_n_i && wr_state != sram_wr_pkg::PH_FIRST)
        |=> s_wr_burst;
    endproperty
    a_wr_start: assert property (p_wr_start) else $error("write not started");
    property p_wr_deselect;
        @(posedge k_clk_i) disable iff (!k_rst_n)
        (write_port_select_n_i && wr_state != sram_wr_pkg::PH_FIRST)
        |=> wr_state == sram_wr_pkg::PH_IDLE;
    endproperty
    a_wr_deselect: assert property (p_wr_deselect) else $error("write ran deselected");
    property p_rd_wins;
        @(posedge k_clk_i) disable iff (!k_rst_n)
        (rd_accept && !write_port_select_n_i) |=> wr_state != sram_wr_pkg::PH_FIRST
        && rd_addr_reg == $past(addr_i);
    endproperty
    a_rd_wins: assert property (p_rd_wins) else $error("address bus conflict");
    property p_addr_hold;
        @(posedge k_clk_i) disable iff (!k_rst_n)
        (!rd_accept && !wr_accept) |=> $stable(wr_addr_reg) && $stable(rd_addr_reg);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address taken while idle");
    property p_wr_addr;
        @(posedge k_clk_i) disable iff (!k_rst_n)
        wr_accept |=> wr_addr_reg == $past(addr_i) ##1 $stable(wr_addr_reg);
    endproperty
    a_wr_addr: assert property (p_wr_addr) else $error("write address lost");
    property p_lane_off;
        @(posedge k_clk_i) disable iff (!k_rst_n)
        (wr_state == sram_wr_pkg::PH_FIRST && sel_n == sram_wr_pkg::SEL_NONE)
        |=> mask1_reg == sram_wr_pkg::DATA_RESET;
    endproperty
    a_lane_off: assert property (p_lane_off) else $error("masked lane written");
    property p_rd_start;
        @(posedge k_clk_i) disable iff (!k_rst_n)
        rd_accept |=> s_rd_burst;
    endproperty
    a_rd_start: assert property (p_rd_start) else $error("read burst wrong");
    property p_drive_on;
        @(posedge k_clk_i) disable iff (!k_rst_n)
        rd_accept |=> (!q_drive_n_o && output_valid_flag_o) [*3];
    endproperty
    a_drive_on: assert property (p_drive_on) else $error("read data not driven");
    property p_drive_off;
        @(posedge k_clk_i) disable iff (!k_rst_n)
        (rd_state == sram_wr_pkg::PH_IDLE && read_port_select_n_i) |=> q_drive_n_o;
    endproperty
    a_drive_off: assert property (p_drive_off) else $error("drivers left on");
endmodule // sram_wr_port

// file: tb/host_link_model.sv
// Host controller model: link clocks, selects, address and write beats.
module host_link_model (
    output logic k_clk_o,
    output logic k_n_clk_o,
    output logic write_port_select_n_o,
    output logic read_port_select_n_o,
    output logic byte_lane0_write_sel_n_o,
    output logic byte_lane1_write_sel_n_o,
    output logic byte_lane2_write_sel_n_o,
    output logic byte_lane3_write_sel_n_o,
    output logic [sram_wr_pkg::ADDR_W-1:0] addr_o,
    output logic [sram_wr_pkg::DATA_W-1:0] wr_data_o,
    input wire logic [sram_wr_pkg::DATA_W-1:0] q_rise_i,
    input wire logic [sram_wr_pkg::DATA_W-1:0] q_fall_i,
    input wire logic q_drive_n_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] sel_n; // Byte selects as one vector
    logic [sram_wr_pkg::DATA_W:0] got[$]; // Drive flag and read word
    assign byte_lane0_write_sel_n_o = sel_n[0];
    assign byte_lane1_write_sel_n_o = sel_n[1];
    assign byte_lane2_write_sel_n_o = sel_n[2];
    assign byte_lane3_write_sel_n_o = sel_n[3];
    assign k_n_clk_o = ~k_clk_o; // Exact complement
    // Free running clock, odd offset against the system clock
    initial
    begin
        k_clk_o = 1'b0;
        #37;
        forever #80 k_clk_o = ~k_clk_o;
    end
    // Quiet bus at time zero
    initial
    begin
        write_port_select_n_o = 1'b1;
        read_port_select_n_o = 1'b1;
        sel_n = 4'hf;
        addr_o = 17'h0_0000;
        wr_data_o = 36'h0_0000_0000;
    end
    // Unused lines change: data inverts, selects and address are redrawn at random, so stale data shows
    task automatic scramble();
        wr_data_o = ~wr_data_o;
        sel_n = 4'($urandom());
        addr_o = 17'($urandom());
    endtask
    // One request, then its four beats; returns before the last beat edge
    task automatic op(input logic rd, input logic wr, input logic [16:0] a,
                      input logic [3:0][35:0] d, input logic [3:0][3:0] s);
        int i;
        begin
            read_port_select_n_o = ~rd; // Active low
            write_port_select_n_o = ~wr; // Active low
            addr_o = a; // Shared address
            @(posedge k_clk_o);
            for (i = 0; i < 4; i++)
            begin
                #1;
                if (i == 0)
                begin
                    read_port_select_n_o = 1'b1;
                    write_port_select_n_o = 1'b1;
                    addr_o = ~a;
                end
                wr_data_o = d[i]; // Four words per burst
                sel_n = s[i]; // Selects ride with their beat
                if (i == 0 || i == 2)
                    @(posedge k_n_clk_o);
                else if (i == 1)
                    @(posedge k_clk_o);
            end
        end
    endtask
    // Idle periods with changing lines; selects are already high here
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge k_clk_o);
            #1 scramble();
            @(posedge k_n_clk_o);
            #1 scramble();
        end
    endtask
    // Selects low only across a negative clock edge
    task automatic kn_pulse();
        @(posedge k_clk_o);
        #1;
        write_port_select_n_o = 1'b0;
        read_port_select_n_o = 1'b0;
        @(posedge k_n_clk_o);
        #1;
        write_port_select_n_o = 1'b1;
        read_port_select_n_o = 1'b1;
    endtask
    // Four read words, alternating output registers
    task automatic capture_burst();
        repeat (2)
        begin
            @(posedge k_n_clk_o);
            #1 got.push_back({q_drive_n_i, q_fall_i});
            @(posedge k_clk_o);
            #1 got.push_back({q_drive_n_i, q_rise_i});
        end
    endtask
    // Start a capture for every read seen at a positive edge
    always @(posedge k_clk_o)
    begin
        if (read_port_select_n_o === 1'b0)
            fork
                capture_burst();
            join_none
    end
endmodule // host_link_model

// file: tb/sync_sram_write_port_address_tb.sv
// Self-checking bench of the write port and shared address logic.
module sync_sram_write_port_address_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic k_clk, k_n_clk, wps_n, rps_n, bs0_n, bs1_n, bs2_n, bs3_n;
    logic [16:0] addr;
    logic [35:0] wdata, q_rise, q_fall;
    logic q_drive_n, valid, wr_done, rd_start;
    logic [35:0] mem[int]; // Reference array, four words per address
    logic [36:0] exp[$]; // Expected read words with drive flag
    logic [16:0] adr[8];
    int bad_count = 0;
    int samples_checked = 0;
    int nwr = 0;
    int nrd = 0;
    int wd_cnt = 0;
    int rs_cnt = 0;
    int j;
    always #5 clock_i = ~clock_i;
    sram_wr_port u_dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .k_clk_i(k_clk), .k_n_clk_i(k_n_clk),
        .write_port_select_n_i(wps_n), .read_port_select_n_i(rps_n),
        .byte_lane0_write_sel_n_i(bs0_n), .byte_lane1_write_sel_n_i(bs1_n),
        .byte_lane2_write_sel_n_i(bs2_n), .byte_lane3_write_sel_n_i(bs3_n),
        .addr_i(addr), .wr_data_i(wdata), .q_rise_o(q_rise), .q_fall_o(q_fall),
        .q_drive_n_o(q_drive_n), .output_valid_flag_o(valid),
        .write_done_o(wr_done), .read_start_o(rd_start)
    );
    host_link_model u_host (
        .k_clk_o(k_clk), .k_n_clk_o(k_n_clk), .write_port_select_n_o(wps_n),
        .read_port_select_n_o(rps_n), .byte_lane0_write_sel_n_o(bs0_n),
        .byte_lane1_write_sel_n_o(bs1_n), .byte_lane2_write_sel_n_o(bs2_n),
        .byte_lane3_write_sel_n_o(bs3_n), .addr_o(addr), .wr_data_o(wdata),
        .q_rise_i(q_rise), .q_fall_i(q_fall), .q_drive_n_i(q_drive_n)
    );
    // Count event pulses away from the edge that launches them
    always @(negedge clock_i)
    begin
        if (wr_done === 1'b1)
            wd_cnt++;
        if (rd_start === 1'b1)
            rs_cnt++;
    end
    // One comparison, counted
    task automatic check(input logic [36:0] got, input logic [36:0] want);
        samples_checked++;
        if (got !== want)
        begin
            bad_count++;
            $display("unexpected at %0t got %h want %h", $time, got, want);
        end
    endtask
    // Verdict and end of run
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Issue one request and update the reference; read wins a collision
    task automatic do_op(input logic rd, input logic wr, input logic [16:0] a,
                         input logic [3:0][3:0] s);
        logic [3:0][35:0] d;
        int i;
        int l;
        begin
            for (i = 0; i < 4; i++)
                d[i] = 36'({$urandom(), $urandom()});
            u_host.op(rd, wr, a, d, s);
            for (i = 0; i < 4; i++)
            begin
                if (rd)
                    exp.push_back({1'b0, mem[int'(a) * 4 + i]});
                else if (wr)
                    for (l = 0; l < 4; l++)
                        if (!s[i][l]) // Deselected lane kept
                            mem[int'(a) * 4 + i][l * sram_wr_pkg::LANE_W +: 9] = d[i][l * 9 +: 9];
            end
            nrd += int'(rd);
            nwr += int'(wr && !rd);
        end
    endtask
    // Hang guard, well beyond the expected 19.6 us
    initial
    begin
        #100000;
        bad_count++;
        $display("unexpected hang at %0t got %h want %h", $time, 1'b0, 1'b1);
        report_and_stop();
    end
    // Main sequence
    initial
    begin
        void'($urandom(2295));
        repeat (4) @(posedge k_clk); // Link clocks toggle through reset
        @(negedge clock_i);
        rst_n_i = 1'b1;
        u_host.idle(4);
        check({36'h0_0000_0000, q_drive_n}, 37'h0_0000_0001); // Idle after reset
        check({36'h0_0000_0000, valid}, 37'h0_0000_0000);
        foreach (adr[i])
            adr[i] = 17'($urandom());
        adr[0] = 17'h0_0000; // Boundary addresses
        adr[1] = 17'h1_ffff;
        // Full writes, back to back
        for (j = 0; j < 8; j++)
            do_op(1'b0, 1'b1, adr[j], 16'h0000);
        // Every byte select pattern on every beat
        for (j = 0; j < 16; j++)
            do_op(1'b0, 1'b1, adr[j % 8], {4'(j), 4'(j + 5), 4'(~j), 4'(j * 3)});
        // Both selects on one edge: write dropped
        for (j = 0; j < 3; j++)
            do_op(1'b1, 1'b1, adr[j], 16'h0000);
        // Pulses that miss the positive edge start nothing
        repeat (3) u_host.kn_pulse();
        u_host.idle(2);
        // Reads mixed with writes to the same place
        for (j = 0; j < 8; j++)
        begin
            do_op(1'b1, 1'b0, adr[j], 16'h0000);
            do_op(1'b0, 1'b1, adr[j], 16'($urandom()));
            do_op(1'b1, 1'b0, adr[j], 16'h0000);
        end
        u_host.idle(3);
        check({36'h0_0000_0000, q_drive_n}, 37'h0_0000_0001); // Tristate
        check({36'h0_0000_0000, valid}, 37'h0_0000_0000);
        u_host.idle(4);
        check(37'(u_host.got.size()), 37'(exp.size()));
        foreach (exp[i])
            if (i < u_host.got.size())
                check(u_host.got[i], exp[i]);
        check(37'(wd_cnt), 37'(nwr)); // Writes committed
        check(37'(rs_cnt), 37'(nrd)); // Reads accepted
        report_and_stop();
    end
endmodule // sync_sram_write_port_address_tb
